/* design/low_voltage_and_stop_control.sv */
`timescale 1ns/100ps
// Overview of operation
// - bit 7 first register: read-only undervolt flag, set on detect only while logic enabled
// - bit 6 first register: write one clears undervolt flag, zero ignored, reads zero
// - bit 5 first register: interrupt enable, request raised while undervolt flag set
// - bit 4 first register: reset enable, set flag forces reset when logic enabled
// - bit 3 first register: detection keeps running during stop when one
// - bit 2 first register: enables undervolt logic, gating flag, irq, reset, stop bits
// - bit 0 first register: turns internal reference buffer on or off
// - bit 7 second register: sticky warning flag, present or once present
// - warning flag sets on supply below warning trip, including after any reset
// - writing one to bit 6 clears warning flag only when warning absent
// - bit 5 second register: detect trip select, zero low, one high
// - bit 4 second register: warning trip select, zero low, one high
// - bit 3 second register: reads one after recovery from partial power down
// - writing one to bit 2 second register clears the recovery flag
// - bit 0 second register: stop mode select, only first write after reset taken
module low_voltage_and_stop_control #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic porRstn,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // supply monitor side
  input wire supply_ctrl_pkg::supply_status_t supplyStatus,
  output supply_ctrl_pkg::analog_ctrl_t analogCtrl,
  output logic undervoltResetReq,
  output logic irq
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (ADDR_W < 4 || ADDR_W > 32) begin
    $error("ADDR_W must lie between 4 and 32");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic undervoltFlag;
  logic undervoltIrqEn;
  logic undervoltResetEn;
  logic undervoltInStopEn;
  logic undervoltLogicEn;
  logic referenceBufferEn;
  logic detectLocked;
  logic supplyWarningFlag;
  logic undervoltTripSelect;
  logic warningTripSelect;
  logic deepStopExitFlag;
  logic deepStopSelect;
  logic deepStopLocked;
  logic [supply_ctrl_pkg::NUM_EVENTS-1:0] irqStatus;
  logic [supply_ctrl_pkg::NUM_EVENTS-1:0] irqMask;

  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wrEn;
  logic rdEn;
  logic [7:0] wrOff;
  logic [7:0] rdOff;
  logic wrByte;
  logic wrDetect;
  logic wrWarn;
  logic wrStatus;
  logic wrMask;
  logic wrHit;
  logic [7:0] wrVal;

  logic detectActive;
  logic next_undervoltFlag;
  logic next_supplyWarningFlag;
  logic next_deepStopExitFlag;
  logic [supply_ctrl_pkg::NUM_EVENTS-1:0] events;
  logic [7:0] detectCtrlRd;
  logic [7:0] warnStopRd;

  // ---------------------------------------------------------------
  // write channel capture
  // ---------------------------------------------------------------
  // address and data are taken in either order; the write happens once both are held
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign wrEn = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (wrEn) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wHeld <= 1'b0;
      wData <= 32'h0;
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (wrEn) begin
      wHeld <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  assign wrOff = 8'(awAddr & ADDR_W'(8'hfc));
  assign wrByte = wrEn && wStrb[0];
  assign wrVal = wData[7:0];
  assign wrDetect = wrByte && (wrOff == supply_ctrl_pkg::OFF_DETECT_CTRL);
  assign wrWarn = wrByte && (wrOff == supply_ctrl_pkg::OFF_WARN_STOP_CTRL);
  assign wrStatus = wrByte && (wrOff == supply_ctrl_pkg::OFF_IRQ_STATUS);
  assign wrMask = wrByte && (wrOff == supply_ctrl_pkg::OFF_IRQ_MASK);
  assign wrHit = (wrOff == supply_ctrl_pkg::OFF_DETECT_CTRL) ||
                 (wrOff == supply_ctrl_pkg::OFF_WARN_STOP_CTRL) ||
                 (wrOff == supply_ctrl_pkg::OFF_IRQ_STATUS) ||
                 (wrOff == supply_ctrl_pkg::OFF_IRQ_MASK);

  // ---------------------------------------------------------------
  // write response
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= supply_ctrl_pkg::RESP_OKAY;
    end else if (wrEn) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? supply_ctrl_pkg::RESP_OKAY : supply_ctrl_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // detect control register
  // ---------------------------------------------------------------
  // monitor sees the comparator only when enabled, and in stop only if allowed
  assign detectActive = undervoltLogicEn && (!supplyStatus.stopActive || undervoltInStopEn);

  always_comb begin
    next_undervoltFlag = undervoltFlag;
    if (wrDetect && wrVal[supply_ctrl_pkg::POS_UNDERVOLT_ACK]) begin
      next_undervoltFlag = 1'b0;
    end
    // set wins over a same-cycle acknowledge
    if (detectActive && supplyStatus.undervoltDetect) begin
      next_undervoltFlag = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      undervoltFlag <= supply_ctrl_pkg::RST_DETECT_CTRL[supply_ctrl_pkg::POS_UNDERVOLT_FLAG];
    end else begin
      undervoltFlag <= next_undervoltFlag;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      undervoltIrqEn <= supply_ctrl_pkg::RST_DETECT_CTRL[supply_ctrl_pkg::POS_UNDERVOLT_IRQ_EN];
      referenceBufferEn <= supply_ctrl_pkg::RST_DETECT_CTRL[supply_ctrl_pkg::POS_REFERENCE_BUFFER_EN];
    end else if (wrDetect) begin
      undervoltIrqEn <= wrVal[supply_ctrl_pkg::POS_UNDERVOLT_IRQ_EN];
      referenceBufferEn <= wrVal[supply_ctrl_pkg::POS_REFERENCE_BUFFER_EN];
    end
  end

  // protection enables freeze after the first write so runaway code cannot drop them
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      detectLocked <= 1'b0;
      undervoltResetEn <= supply_ctrl_pkg::RST_DETECT_CTRL[supply_ctrl_pkg::POS_UNDERVOLT_RESET_EN];
      undervoltInStopEn <= supply_ctrl_pkg::RST_DETECT_CTRL[supply_ctrl_pkg::POS_UNDERVOLT_IN_STOP_EN];
      undervoltLogicEn <= supply_ctrl_pkg::RST_DETECT_CTRL[supply_ctrl_pkg::POS_UNDERVOLT_LOGIC_EN];
    end else if (wrDetect && !detectLocked) begin
      detectLocked <= 1'b1;
      undervoltResetEn <= wrVal[supply_ctrl_pkg::POS_UNDERVOLT_RESET_EN];
      undervoltInStopEn <= wrVal[supply_ctrl_pkg::POS_UNDERVOLT_IN_STOP_EN];
      undervoltLogicEn <= wrVal[supply_ctrl_pkg::POS_UNDERVOLT_LOGIC_EN];
    end
  end

  // ---------------------------------------------------------------
  // warning and stop control register
  // ---------------------------------------------------------------
  always_comb begin
    next_supplyWarningFlag = supplyWarningFlag;
    if (wrWarn && wrVal[supply_ctrl_pkg::POS_SUPPLY_WARNING_ACK] && !supplyStatus.supplyWarning) begin
      next_supplyWarningFlag = 1'b0;
    end
    // level input, so a supply already low after reset sets it at once
    if (supplyStatus.supplyWarning) begin
      next_supplyWarningFlag = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      supplyWarningFlag <= supply_ctrl_pkg::RST_WARN_STOP_CTRL[supply_ctrl_pkg::POS_SUPPLY_WARNING_FLAG];
    end else begin
      supplyWarningFlag <= next_supplyWarningFlag;
    end
  end

  // trip selects sit on the power-on reset only and survive all other resets
  always_ff @(posedge mclk or negedge porRstn) begin
    if (!porRstn) begin
      undervoltTripSelect <= supply_ctrl_pkg::RST_WARN_STOP_CTRL[supply_ctrl_pkg::POS_UNDERVOLT_TRIP_SELECT];
      warningTripSelect <= supply_ctrl_pkg::RST_WARN_STOP_CTRL[supply_ctrl_pkg::POS_WARNING_TRIP_SELECT];
    end else if (wrWarn) begin
      undervoltTripSelect <= wrVal[supply_ctrl_pkg::POS_UNDERVOLT_TRIP_SELECT];
      warningTripSelect <= wrVal[supply_ctrl_pkg::POS_WARNING_TRIP_SELECT];
    end
  end

  always_comb begin
    next_deepStopExitFlag = deepStopExitFlag;
    if (wrWarn && wrVal[supply_ctrl_pkg::POS_DEEP_STOP_EXIT_ACK]) begin
      next_deepStopExitFlag = 1'b0;
    end
    if (supplyStatus.deepStopExit) begin
      next_deepStopExitFlag = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      deepStopExitFlag <= supply_ctrl_pkg::RST_WARN_STOP_CTRL[supply_ctrl_pkg::POS_DEEP_STOP_EXIT_FLAG];
    end else begin
      deepStopExitFlag <= next_deepStopExitFlag;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      deepStopLocked <= 1'b0;
      deepStopSelect <= supply_ctrl_pkg::RST_WARN_STOP_CTRL[supply_ctrl_pkg::POS_DEEP_STOP_SELECT];
    end else if (wrWarn && !deepStopLocked) begin
      deepStopLocked <= 1'b1;
      deepStopSelect <= wrVal[supply_ctrl_pkg::POS_DEEP_STOP_SELECT];
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  // events are the rising of each flag, so a held level interrupts once
  always_comb begin
    events = '0;
    events[supply_ctrl_pkg::POS_EV_UNDERVOLT] = next_undervoltFlag && !undervoltFlag;
    events[supply_ctrl_pkg::POS_EV_WARNING] = next_supplyWarningFlag && !supplyWarningFlag;
    events[supply_ctrl_pkg::POS_EV_DEEP_STOP_EXIT] = next_deepStopExitFlag && !deepStopExitFlag;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irqStatus <= supply_ctrl_pkg::RST_IRQ_STATUS;
    end else if (wrStatus) begin
      irqStatus <= (irqStatus & ~wrVal[supply_ctrl_pkg::NUM_EVENTS-1:0]) | events;
    end else begin
      irqStatus <= irqStatus | events;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irqMask <= supply_ctrl_pkg::RST_IRQ_MASK;
    end else if (wrMask) begin
      irqMask <= wrVal[supply_ctrl_pkg::NUM_EVENTS-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(irqStatus & irqMask)) || (undervoltIrqEn && undervoltFlag);
    end
  end

  // ---------------------------------------------------------------
  // reset request and analog controls
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      undervoltResetReq <= 1'b0;
    end else begin
      undervoltResetReq <= undervoltLogicEn && undervoltResetEn && undervoltFlag;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      analogCtrl <= '0;
    end else begin
      analogCtrl.referenceBufferEn <= referenceBufferEn;
      analogCtrl.undervoltTripSelect <= undervoltTripSelect;
      analogCtrl.warningTripSelect <= warningTripSelect;
      analogCtrl.deepStopSelect <= deepStopSelect;
      analogCtrl.undervoltDetectActive <= detectActive;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // reserved bit 1 is never stored; software is expected to keep it zero
  always_comb begin
    detectCtrlRd = 8'h00;
    detectCtrlRd[supply_ctrl_pkg::POS_UNDERVOLT_FLAG] = undervoltFlag;
    detectCtrlRd[supply_ctrl_pkg::POS_UNDERVOLT_IRQ_EN] = undervoltIrqEn;
    detectCtrlRd[supply_ctrl_pkg::POS_UNDERVOLT_RESET_EN] = undervoltResetEn;
    detectCtrlRd[supply_ctrl_pkg::POS_UNDERVOLT_IN_STOP_EN] = undervoltInStopEn;
    detectCtrlRd[supply_ctrl_pkg::POS_UNDERVOLT_LOGIC_EN] = undervoltLogicEn;
    detectCtrlRd[supply_ctrl_pkg::POS_REFERENCE_BUFFER_EN] = referenceBufferEn;
  end

  always_comb begin
    warnStopRd = 8'h00;
    warnStopRd[supply_ctrl_pkg::POS_SUPPLY_WARNING_FLAG] = supplyWarningFlag;
    warnStopRd[supply_ctrl_pkg::POS_UNDERVOLT_TRIP_SELECT] = undervoltTripSelect;
    warnStopRd[supply_ctrl_pkg::POS_WARNING_TRIP_SELECT] = warningTripSelect;
    warnStopRd[supply_ctrl_pkg::POS_DEEP_STOP_EXIT_FLAG] = deepStopExitFlag;
    warnStopRd[supply_ctrl_pkg::POS_DEEP_STOP_SELECT] = deepStopSelect;
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign rdEn = s_axi_arvalid && s_axi_arready;
  assign rdOff = 8'(s_axi_araddr & ADDR_W'(8'hfc));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= supply_ctrl_pkg::RESP_OKAY;
    end else if (rdEn) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= supply_ctrl_pkg::RESP_OKAY;
      unique case (rdOff)
        supply_ctrl_pkg::OFF_DETECT_CTRL: begin
          s_axi_rdata <= {24'h0, detectCtrlRd};
        end
        supply_ctrl_pkg::OFF_WARN_STOP_CTRL: begin
          s_axi_rdata <= {24'h0, warnStopRd};
        end
        supply_ctrl_pkg::OFF_IRQ_STATUS: begin
          s_axi_rdata <= {29'h0, irqStatus};
        end
        supply_ctrl_pkg::OFF_IRQ_MASK: begin
          s_axi_rdata <= {29'h0, irqMask};
        end
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= supply_ctrl_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* dv/low_voltage_and_stop_control_tb.sv */
`timescale 1ns/100ps
module low_voltage_and_stop_control_tb;
  logic mclk = 1'b0, rstn = 1'b0, porRstn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, ureq, irq;
  logic [1:0] bresp, rresp, rr;
  supply_ctrl_pkg::supply_status_t st = '0;
  supply_ctrl_pkg::analog_ctrl_t ac;
  int errors = 0, total_checks = 0, cycles = 0;
  always #4 mclk = ~mclk;
  low_voltage_and_stop_control dut (
    .mclk(mclk), .rstn(rstn), .porRstn(porRstn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .supplyStatus(st), .analogCtrl(ac), .undervoltResetReq(ureq), .irq(irq));
  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task wrap_up;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      wrap_up;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // ready is sampled mid-cycle: inputs only move after rising edges
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic at, wt, bt;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bt = 1'b0;
    while (!bt) begin
      @(negedge mclk);
      at = awvalid && awready;
      wt = wvalid && wready;
      bt = bvalid;
      rr = bresp;
      @(posedge mclk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", er, rr);
  endtask
  task rdv(input logic [7:0] a, input logic [1:0] er);
    logic at, rt;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rt = 1'b0;
    while (!rt) begin
      @(negedge mclk);
      at = arvalid && arready;
      rt = rvalid;
      rd = rdata;
      rr = rresp;
      @(posedge mclk);
      if (at) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("rresp", er, rr);
  endtask
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    rdv(a, supply_ctrl_pkg::RESP_OKAY);
    chk(n, e, rd);
  endtask
  task pulse(input logic [3:0] m);
    @(posedge mclk);
    st <= st | m;
    @(posedge mclk);
    st <= st & ~m;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  task rst(input logic por);
    @(posedge mclk);
    rstn <= 1'b0;
    if (por) porRstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    porRstn <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_map;
    for (int i = 0; i < 4; i++) rdc("reset value", 8'(i * 4), 32'h0);
    rdv(8'h10, supply_ctrl_pkg::RESP_SLVERR);
    wr(8'h10, 8'hff, supply_ctrl_pkg::RESP_SLVERR);
  endtask
  task t_detect;
    wr(8'h00, 8'h65, supply_ctrl_pkg::RESP_OKAY);
    rdc("detect", 8'h00, 32'h25);
    chk("refbuf", 32'h1, 32'(ac.referenceBufferEn));
    wr(8'h00, 8'h1c, supply_ctrl_pkg::RESP_OKAY);
    rdc("detect once", 8'h00, 32'h04);
    wr(8'h00, 8'h21, supply_ctrl_pkg::RESP_OKAY);
    @(posedge mclk);
    st.stopActive <= 1'b1;
    pulse(4'h8);
    rdc("stop masked", 8'h00, 32'h25);
    chk("active in stop", 32'h0, 32'(ac.undervoltDetectActive));
    st.stopActive <= 1'b0;
    pulse(4'h8);
    rdc("flag", 8'h00, 32'ha5);
    chk("irq on", 32'h1, 32'(irq));
    rdc("status", 8'h08, 32'h1);
    wr(8'h00, 8'h61, supply_ctrl_pkg::RESP_OKAY);
    rdc("acked", 8'h00, 32'h25);
    @(negedge mclk);
    chk("irq off", 32'h0, 32'(irq));
    wr(8'h0c, 8'h01, supply_ctrl_pkg::RESP_OKAY);
    @(negedge mclk);
    chk("irq mask", 32'h1, 32'(irq));
    wr(8'h08, 8'h01, supply_ctrl_pkg::RESP_OKAY);
    @(negedge mclk);
    chk("irq clear", 32'h0, 32'(irq));
    rdc("status w1c", 8'h08, 32'h0);
  endtask
  task t_stopsel;
    rst(1'b1);
    wr(8'h04, 8'h31, supply_ctrl_pkg::RESP_OKAY);
    rdc("warn reg", 8'h04, 32'h31);
    chk("analog", 32'h7, 32'({ac.undervoltTripSelect, ac.warningTripSelect, ac.deepStopSelect}));
    wr(8'h04, 8'h00, supply_ctrl_pkg::RESP_OKAY);
    rdc("select once", 8'h04, 32'h01);
    wr(8'h04, 8'h30, supply_ctrl_pkg::RESP_OKAY);
    rst(1'b0);
    rdc("kept trips", 8'h04, 32'h30);
    rst(1'b1);
    rdc("por clear", 8'h04, 32'h00);
  endtask
  task t_undervolt;
    wr(8'h00, 8'h10, supply_ctrl_pkg::RESP_OKAY);
    pulse(4'h8);
    rdc("no logic", 8'h00, 32'h10);
    chk("no reset", 32'h0, 32'(ureq));
    rst(1'b0);
    // detection kept running in stop this time
    wr(8'h00, 8'h1c, supply_ctrl_pkg::RESP_OKAY);
    st.stopActive <= 1'b1;
    pulse(4'h8);
    chk("active stop en", 32'h1, 32'(ac.undervoltDetectActive));
    chk("reset req", 32'h1, 32'(ureq));
    rdc("flag rst", 8'h00, 32'h9c);
    st.stopActive <= 1'b0;
  endtask
  task t_warning;
    @(posedge mclk);
    st.supplyWarning <= 1'b1;
    rst(1'b0);
    rdc("warn at reset", 8'h04, 32'h80);
    wr(8'h04, 8'h40, supply_ctrl_pkg::RESP_OKAY);
    rdc("ack refused", 8'h04, 32'h80);
    st.supplyWarning <= 1'b0;
    repeat (2) @(posedge mclk);
    rdc("sticky", 8'h04, 32'h80);
    wr(8'h04, 8'h40, supply_ctrl_pkg::RESP_OKAY);
    rdc("ack taken", 8'h04, 32'h00);
    rdc("warn event", 8'h08, 32'h2);
    // exit held as a level across the read so the checker sees it
    st.deepStopExit <= 1'b1;
    rdc("exit flag", 8'h04, 32'h08);
    st.deepStopExit <= 1'b0;
    rdc("exit event", 8'h08, 32'h6);
    wr(8'h04, 8'h04, supply_ctrl_pkg::RESP_OKAY);
    rdc("exit ack", 8'h04, 32'h00);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    porRstn <= 1'b1;
    repeat (2) @(posedge mclk);
    t_map;
    t_detect;
    t_stopsel;
    t_undervolt;
    t_warning;
    wrap_up;
  end
endmodule

/* dv/supply_ctrl_properties.sv */
`timescale 1ns/100ps
module supply_ctrl_properties #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire supply_ctrl_pkg::supply_status_t supplyStatus,
  input wire supply_ctrl_pkg::analog_ctrl_t analogCtrl
);
  // ---------------------------------------------------------------
  // read address tracking
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] rdAddr;
  logic [1:0] warm;
  logic isDet, isWarn;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdAddr <= '0;
      warm <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rdAddr <= s_axi_araddr;
      end
      // past values right after reset still see reset-time inputs
      if (warm != 2'h3) begin
        warm <= warm + 2'h1;
      end
    end
  end
  assign isDet = rdAddr[ADDR_W-1:2] == '0;
  assign isWarn = rdAddr[ADDR_W-1:2] == (ADDR_W-2)'(1);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  ack_zero_a: assert property (
    $rose(s_axi_rvalid) && isDet |-> s_axi_rdata[6] == 1'b0) else $error("detect ack read as one");
  flag_gate_a: assert property (
    $rose(s_axi_rvalid) && isDet && s_axi_rdata[7] |-> s_axi_rdata[2]) else $error("flag set without enable");
  buf_mirror_a: assert property (
    $rose(s_axi_rvalid) && isDet && !s_axi_bvalid |-> analogCtrl.referenceBufferEn == s_axi_rdata[0])
    else $error("buffer enable differs from register");
  zero_bits_a: assert property (
    $rose(s_axi_rvalid) && isWarn |-> s_axi_rdata[6] == 1'b0 && s_axi_rdata[2:1] == 2'h0)
    else $error("ack or unused bit read as one");
  trip_mirror_a: assert property (
    $rose(s_axi_rvalid) && isWarn && !s_axi_bvalid |->
    {analogCtrl.undervoltTripSelect, analogCtrl.warningTripSelect} == s_axi_rdata[5:4])
    else $error("trip selects differ from register");
  warn_sticky_a: assert property (
    $rose(s_axi_rvalid) && isWarn && warm == 2'h3 && $past(supplyStatus.supplyWarning, 2) |-> s_axi_rdata[7])
    else $error("warning flag missing");
  exit_flag_a: assert property (
    $rose(s_axi_rvalid) && isWarn && warm == 2'h3 && $past(supplyStatus.deepStopExit, 2) |-> s_axi_rdata[3])
    else $error("deep stop exit flag missing");
  b_once_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answer repeated");
  r_once_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer repeated");
endmodule

bind low_voltage_and_stop_control supply_ctrl_properties #(.ADDR_W(ADDR_W)) props (
  .mclk(mclk), .rstn(rstn), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .supplyStatus(supplyStatus), .analogCtrl(analogCtrl));

/* inc/supply_ctrl_pkg.sv */
package supply_ctrl_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_DETECT_CTRL = 8'h00;
  localparam logic [7:0] OFF_WARN_STOP_CTRL = 8'h04;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;

  // ---------------------------------------------------------------
  // field positions, detect control
  // ---------------------------------------------------------------
  localparam int POS_UNDERVOLT_FLAG = 7;
  localparam int POS_UNDERVOLT_ACK = 6;
  localparam int POS_UNDERVOLT_IRQ_EN = 5;
  localparam int POS_UNDERVOLT_RESET_EN = 4;
  localparam int POS_UNDERVOLT_IN_STOP_EN = 3;
  localparam int POS_UNDERVOLT_LOGIC_EN = 2;
  localparam int POS_REFERENCE_BUFFER_EN = 0;

  // ---------------------------------------------------------------
  // field positions, warning and stop control
  // ---------------------------------------------------------------
  localparam int POS_SUPPLY_WARNING_FLAG = 7;
  localparam int POS_SUPPLY_WARNING_ACK = 6;
  localparam int POS_UNDERVOLT_TRIP_SELECT = 5;
  localparam int POS_WARNING_TRIP_SELECT = 4;
  localparam int POS_DEEP_STOP_EXIT_FLAG = 3;
  localparam int POS_DEEP_STOP_EXIT_ACK = 2;
  localparam int POS_DEEP_STOP_SELECT = 0;

  // ---------------------------------------------------------------
  // interrupt status and mask layout
  // ---------------------------------------------------------------
  localparam int POS_EV_UNDERVOLT = 0;
  localparam int POS_EV_WARNING = 1;
  localparam int POS_EV_DEEP_STOP_EXIT = 2;
  localparam int NUM_EVENTS = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_DETECT_CTRL = 8'h00;
  localparam logic [7:0] RST_WARN_STOP_CTRL = 8'h00;
  localparam logic [NUM_EVENTS-1:0] RST_IRQ_STATUS = 3'h0;
  localparam logic [NUM_EVENTS-1:0] RST_IRQ_MASK = 3'h0;

  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // settings that steer the analog side
  typedef struct packed {
    logic referenceBufferEn;
    logic undervoltTripSelect;
    logic warningTripSelect;
    logic deepStopSelect;
    logic undervoltDetectActive;
  } analog_ctrl_t;

  // comparator and power-mode inputs
  typedef struct packed {
    logic undervoltDetect;
    logic supplyWarning;
    logic stopActive;
    logic deepStopExit;
  } supply_status_t;

endpackage
